/* include/synth_ctrl_pkg.sv */
// shared constants and types for the synthesizer serial control logic
package synth_ctrl_pkg;
    // ***************************************************
    // serial word framing
    // ***************************************************
    localparam int WORD_BITS = 24;
    localparam logic [1:0] ADDR_A = 2'h0;   // bits 23:22
    localparam logic [1:0] ADDR_B = 2'h1;   // bits 23:22
    localparam logic [2:0] ADDR_C = 3'h4;   // bits 23:21
    localparam logic [2:0] ADDR_D = 3'h5;   // bits 23:21
    localparam int C_LOW_POS  = 0;          // gain select low in the C word
    localparam int C_HIGH_POS = 1;          // gain select high in the C word
    localparam int D_SPU_POS  = 0;          // continuous speed-up test bit
    localparam int D_DIS_POS  = 1;          // speed-up disable test bit

    // A word payload, bits 21:0
    typedef struct packed {
        logic        fmod;
        logic [2:0]  nf;
        logic [15:0] n_ratio;
        logic [1:0]  spare;
    } a_word_t;

    // B word payload, bits 21:0
    typedef struct packed {
        logic [9:0]  ref_div;
        logic [1:0]  lock_mode;
        logic        sw_pd_main;
        logic        sw_pd_aux;
        logic [7:0]  comp_dac_value;
    } b_word_t;

    // ***************************************************
    // values after reset
    // ***************************************************
    localparam a_word_t A_RESET = '{fmod: 1'b1, nf: 3'h0, n_ratio: 16'h88C0, spare: 2'h0};
    localparam b_word_t B_RESET = '{ref_div: 10'h051, lock_mode: 2'h0, sw_pd_main: 1'b1,
                                    sw_pd_aux: 1'b1, comp_dac_value: 8'h50};
    localparam logic [20:0] C_RESET = 21'h000000;
    localparam logic [20:0] D_RESET = 21'h000000;

    // ***************************************************
    // pump scale factors, in units of half the bias current
    // ***************************************************
    localparam logic [6:0] AUX_HI = 7'h03;    // 1.5x
    localparam logic [6:0] AUX_LO = 7'h01;    // 0.5x
    localparam logic [6:0] PROP_HI = 7'h06;   // 3x
    localparam logic [6:0] PROP_LO = 7'h02;   // 1x
    localparam logic [6:0] SU_HI = 7'h1E;     // 15x
    localparam logic [6:0] SU_LO = 7'h0A;     // 5x
    localparam logic [6:0] INT_HI = 7'h48;    // 36x
    localparam logic [6:0] INT_LO = 7'h18;    // 12x
    localparam logic [6:0] INT_OFF = 7'h00;

    // ***************************************************
    // register map, byte addresses
    // ***************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_A = 8'h08;
    localparam logic [7:0] REG_B = 8'h0C;
    localparam logic [7:0] REG_C = 8'h10;
    localparam logic [7:0] REG_D = 8'h14;
    localparam logic [7:0] REG_ACTIVE = 8'h18;
    localparam logic [31:0] CTRL_RESET = 32'h00000001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* logic/synth_serial_ctrl.sv */
// serial programming, speed-up, pump gain, lock and power control of the synthesizer
`timescale 1ns/100ps
// Notes on behaviour
// [R1] three-wire serial bus, 24-bit words, two or three address bits
// [R2] serial clock ignored while strobe high
// [R3] strobe rise loads the addressed register
// [R4] host sends C, B, then A
// [R5] host first writes an all-zero test word
// [R6] DAC bits wait until an A word loads
// [R7] speed-up lasts while the strobe after an A word is high
// [R8] host sizes that strobe to the filter charge time
// [R9] continuous test bit holds speed-up on
// [R10] disable test bit keeps speed-up off
// [R11] main pumps follow main detector, aux pump follows aux
// [R12] gain select low picks the pump scales
// [R13] gain select high zeroes the integral pump
// [R14] lock while both detectors report lock
// [R15] locked means error under one reference period
// [R16] one loop down: other decides; both down: no lock
// [R17] power is pin XOR software bit
// [R18] power-up resynchronises the dividers
// [R19] speed-up from A load with strobe high to strobe low
// [R20] new ratio taken at a divider cycle boundary
// [R21] data shifts on rising serial clock, first bit to LSB
// [R22] disable bit beats continuous bit
// [R23] registers hold defaults after reset
module synth_serial_ctrl
(
    input  wire logic        core_clk, // 100 MHz clock
    input  wire logic        rst_n, // asynchronous reset
    input  wire logic        ser_clk, // serial clock pin
    input  wire logic        ser_strobe, // serial strobe pin
    input  wire logic        ser_data, // serial data pin
    input  wire logic        hw_power_pin, // hardware power pin
    input  wire logic        main_pd_up, // main detector up
    input  wire logic        main_pd_dn, // main detector down
    input  wire logic        aux_pd_up, // aux detector up
    input  wire logic        aux_pd_dn, // aux detector down
    input  wire logic        main_in_window, // main error small
    input  wire logic        aux_in_window, // aux error small
    input  wire logic        main_div_cycle_end, // main divider boundary
    output logic             prop_pump_up, // proportional source
    output logic             prop_pump_dn, // proportional sink
    output logic             integral_pump_up, // integral source
    output logic             integral_pump_dn, // integral sink
    output logic             aux_pump_up, // aux source
    output logic             aux_pump_dn, // aux sink
    output logic [6:0]       prop_pump_out, // proportional scale
    output logic [6:0]       prop_pump_speedup, // speed-up scale
    output logic [6:0]       integral_pump_out, // integral scale
    output logic [6:0]       aux_pump_out, // aux scale
    output logic             speedup, // pumps in speed-up
    output logic             lock, // combined lock
    output logic             main_power_up, // main loop powered
    output logic             aux_power_up, // aux loop powered
    output logic             div_resync, // divider resync pulse
    output logic [15:0]      n_ratio_active, // main ratio in use
    output logic             fmod_active, // modulus in use
    output logic [2:0]       nf_active, // increment in use
    output logic [7:0]       comp_dac, // DAC working value
    output logic [9:0]       ref_div, // reference ratio
    input  wire logic [31:0] s_axi_awaddr, // write address
    input  wire logic        s_axi_awvalid, // address valid
    output logic             s_axi_awready, // address ready
    input  wire logic [31:0] s_axi_wdata, // write data
    input  wire logic [3:0]  s_axi_wstrb, // write strobes
    input  wire logic        s_axi_wvalid, // data valid
    output logic             s_axi_wready, // data ready
    output logic [1:0]       s_axi_bresp, // write response
    output logic             s_axi_bvalid, // response valid
    input  wire logic        s_axi_bready, // response ready
    input  wire logic [31:0] s_axi_araddr, // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata, // read data
    output logic [1:0]       s_axi_rresp, // read response
    output logic             s_axi_rvalid, // read data valid
    input  wire logic        s_axi_rready // read data ready
);
    // ***************************************************
    // pin synchronisers
    // ***************************************************
    logic [3:0] meta1_r, meta2_r, meta3_r, pin_r;
    logic       sclk_d_r, stb_d_r, pwr_main_d_r, pwr_aux_d_r;

    // three stages; a level counts once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta1_r <= 4'h0;
            meta2_r <= 4'h0;
            meta3_r <= 4'h0;
            pin_r   <= 4'h0;
        end
        else
        begin
            meta1_r <= {hw_power_pin, ser_data, ser_strobe, ser_clk};
            meta2_r <= meta1_r;
            meta3_r <= meta2_r;
            pin_r   <= (meta2_r & meta3_r) | (pin_r & (meta2_r ^ meta3_r));
        end
    end

    logic sclk_s, stb_s, data_s, pon_s;
    assign sclk_s = pin_r[0];
    assign stb_s  = pin_r[1];
    assign data_s = pin_r[2];
    assign pon_s  = pin_r[3];

    logic sclk_rise, stb_rise, stb_fall;
    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign stb_rise  = stb_s & ~stb_d_r;
    assign stb_fall  = ~stb_s & stb_d_r;

    // ***************************************************
    // serial shift register and word decode
    // ***************************************************
    logic [23:0] shift_r;
    synth_ctrl_pkg::a_word_t a_r;
    synth_ctrl_pkg::b_word_t b_r;
    logic [20:0] c_r, d_r;
    logic        ser_en;                 // software gate on word acceptance
    logic        a_pending_r;            // A word waits for divider boundary

    // first bit in ends at bit 0 after 24 clocks
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            shift_r <= 24'h000000;
        else if (sclk_rise && !stb_s)   // [R2]
            shift_r <= {data_s, shift_r[23:1]};   // [R21] [R1]
    end

    // latch payload into the addressed register when strobe rises
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_r <= synth_ctrl_pkg::A_RESET;   // [R23]
            b_r <= synth_ctrl_pkg::B_RESET;
            c_r <= synth_ctrl_pkg::C_RESET;
            d_r <= synth_ctrl_pkg::D_RESET;
        end
        else if (stb_rise && ser_en)
        begin
            if (shift_r[23:22] == synth_ctrl_pkg::ADDR_A)   // [R3]
                a_r <= shift_r[21:0];
            else if (shift_r[23:22] == synth_ctrl_pkg::ADDR_B)
                b_r <= shift_r[21:0];   // dac bits stay temporary here [R6]
            else if (shift_r[23:21] == synth_ctrl_pkg::ADDR_C)
                c_r <= shift_r[20:0];
            else if (shift_r[23:21] == synth_ctrl_pkg::ADDR_D)
                d_r <= shift_r[20:0];
        end
    end

    logic a_load;
    assign a_load = stb_rise && ser_en && (shift_r[23:22] == synth_ctrl_pkg::ADDR_A);

    // ***************************************************
    // ratio and dac handover at the divider boundary
    // ***************************************************
    // waits for the cycle end so the divider never sees a torn ratio
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_pending_r    <= 1'b0;
            n_ratio_active <= synth_ctrl_pkg::A_RESET.n_ratio;
            fmod_active    <= synth_ctrl_pkg::A_RESET.fmod;
            nf_active      <= synth_ctrl_pkg::A_RESET.nf;
            comp_dac       <= synth_ctrl_pkg::B_RESET.comp_dac_value;
        end
        else
        begin
            if (a_load)
                a_pending_r <= 1'b1;
            else if (main_div_cycle_end)
                a_pending_r <= 1'b0;
            if (a_pending_r && main_div_cycle_end)   // [R20]
            begin
                n_ratio_active <= a_r.n_ratio;
                fmod_active    <= a_r.fmod;
                nf_active      <= a_r.nf;
                comp_dac       <= b_r.comp_dac_value;   // [R6]
            end
        end
    end

    // ***************************************************
    // speed-up control
    // ***************************************************
    logic su_window_r;

    // window opens at an A load and closes with the strobe
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            su_window_r <= 1'b0;
        else if (stb_fall)   // [R19]
            su_window_r <= 1'b0;
        else if (a_load)   // [R7] [R19]
            su_window_r <= 1'b1;
    end

    logic su_nxt;
    always_comb
    begin
        if (d_r[synth_ctrl_pkg::D_DIS_POS])   // [R10] [R22]
            su_nxt = 1'b0;
        else if (d_r[synth_ctrl_pkg::D_SPU_POS])   // [R9]
            su_nxt = 1'b1;
        else
            su_nxt = su_window_r;   // [R7]
    end

    // ***************************************************
    // power, lock and pump steering
    // ***************************************************
    logic pwr_main_nxt, pwr_aux_nxt, lock_nxt;
    assign pwr_main_nxt = pon_s ^ b_r.sw_pd_main;   // [R17]
    assign pwr_aux_nxt  = pon_s ^ b_r.sw_pd_aux;    // [R17]
    // a powered-down loop drops out of the lock product
    assign lock_nxt = (pwr_main_nxt | pwr_aux_nxt)   // [R16]
                    & (~pwr_main_nxt | main_in_window)   // [R14] [R15]
                    & (~pwr_aux_nxt | aux_in_window);

    logic gsel_low, gsel_high;
    assign gsel_low  = c_r[synth_ctrl_pkg::C_LOW_POS];
    assign gsel_high = c_r[synth_ctrl_pkg::C_HIGH_POS];

    // all outputs registered; a one-cycle lag is harmless at loop rates
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_d_r          <= 1'b0;
            stb_d_r           <= 1'b0;
            pwr_main_d_r      <= 1'b0;
            pwr_aux_d_r       <= 1'b0;
            main_power_up     <= 1'b0;
            aux_power_up      <= 1'b0;
            div_resync        <= 1'b0;
            lock              <= 1'b0;
            speedup           <= 1'b0;
            prop_pump_up      <= 1'b0;
            prop_pump_dn      <= 1'b0;
            integral_pump_up  <= 1'b0;
            integral_pump_dn  <= 1'b0;
            aux_pump_up       <= 1'b0;
            aux_pump_dn       <= 1'b0;
            prop_pump_out     <= synth_ctrl_pkg::PROP_HI;
            prop_pump_speedup <= synth_ctrl_pkg::SU_HI;
            integral_pump_out <= synth_ctrl_pkg::INT_HI;
            aux_pump_out      <= synth_ctrl_pkg::AUX_HI;
            ref_div           <= synth_ctrl_pkg::B_RESET.ref_div;
        end
        else
        begin
            sclk_d_r      <= sclk_s;
            stb_d_r       <= stb_s;
            pwr_main_d_r  <= pwr_main_nxt;
            pwr_aux_d_r   <= pwr_aux_nxt;
            main_power_up <= pwr_main_nxt;
            aux_power_up  <= pwr_aux_nxt;
            div_resync    <= pwr_main_nxt & ~pwr_main_d_r;   // [R18]
            lock          <= lock_nxt;
            speedup       <= su_nxt;
            ref_div       <= b_r.ref_div;
            prop_pump_up     <= main_pd_up & pwr_main_nxt;   // [R11]
            prop_pump_dn     <= main_pd_dn & pwr_main_nxt;
            integral_pump_up <= main_pd_up & pwr_main_nxt & ~gsel_high;   // [R13]
            integral_pump_dn <= main_pd_dn & pwr_main_nxt & ~gsel_high;
            aux_pump_up      <= aux_pd_up & pwr_aux_nxt;   // [R11]
            aux_pump_dn      <= aux_pd_dn & pwr_aux_nxt;
            aux_pump_out  <= gsel_low ? synth_ctrl_pkg::AUX_LO : synth_ctrl_pkg::AUX_HI; // [R12]
            prop_pump_out <= gsel_low ? synth_ctrl_pkg::PROP_LO : synth_ctrl_pkg::PROP_HI;
            prop_pump_speedup <= gsel_low ? synth_ctrl_pkg::SU_LO : synth_ctrl_pkg::SU_HI;
            if (gsel_high)   // [R13]
                integral_pump_out <= synth_ctrl_pkg::INT_OFF;
            else
                integral_pump_out <= gsel_low ? synth_ctrl_pkg::INT_LO : synth_ctrl_pkg::INT_HI;
        end
    end

    // ***************************************************
    // axi4-lite register slave
    // ***************************************************
    logic [31:0] ctrl_r;
    logic        aw_got_r, w_got_r;
    logic [7:0]  waddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    assign ser_en = ctrl_r[0];

    // address and data taken in either order; response once both are in
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            waddr_r       <= 8'h00;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= synth_ctrl_pkg::RESP_OKAY;
            ctrl_r        <= synth_ctrl_pkg::CTRL_RESET;
        end
        else
        begin
            s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
            s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
            if (s_axi_awready && s_axi_awvalid)
            begin
                aw_got_r <= 1'b1;
                waddr_r  <= s_axi_awaddr[7:0];
            end
            if (s_axi_wready && s_axi_wvalid)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid)
            begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (waddr_r == synth_ctrl_pkg::REG_CTRL)
                begin
                    s_axi_bresp <= synth_ctrl_pkg::RESP_OKAY;
                    if (wstrb_r[0])
                        ctrl_r[7:0] <= {7'h00, wdata_r[0]};
                end
                else
                    s_axi_bresp <= synth_ctrl_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    logic [31:0] rd_nxt;
    logic        rd_ok;
    always_comb
    begin
        rd_ok  = 1'b1;
        rd_nxt = 32'h00000000;
        case (s_axi_araddr[7:0])
            synth_ctrl_pkg::REG_CTRL:   rd_nxt = ctrl_r;
            synth_ctrl_pkg::REG_STATUS: rd_nxt = {26'h0000000, a_pending_r, div_resync,
                                                  aux_power_up, main_power_up, speedup, lock};
            synth_ctrl_pkg::REG_A:      rd_nxt = {10'h000, a_r};
            synth_ctrl_pkg::REG_B:      rd_nxt = {10'h000, b_r};
            synth_ctrl_pkg::REG_C:      rd_nxt = {11'h000, c_r};
            synth_ctrl_pkg::REG_D:      rd_nxt = {11'h000, d_r};
            synth_ctrl_pkg::REG_ACTIVE: rd_nxt = {4'h0, comp_dac, fmod_active, nf_active,
                                                  n_ratio_active};
            default:                    rd_ok = 1'b0;
        endcase
    end

    // one read at a time; data answered the cycle after the address is taken
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= synth_ctrl_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (s_axi_arready && s_axi_arvalid)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_nxt;
                s_axi_rresp  <= rd_ok ? synth_ctrl_pkg::RESP_OKAY : synth_ctrl_pkg::RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* verification/host_serial_model.sv */
// host side model of the three-wire programming bus
`timescale 1ns/100ps
module host_serial_model
(
    output logic ser_clk,    // serial clock
    output logic ser_strobe, // strobe
    output logic ser_data    // data
);
    // all idle low: a high strobe at reset would load an empty A word
    initial
    begin
        ser_clk = 1'b0;
        ser_strobe = 1'b0;
        ser_data = 1'b0;
    end
    // one 24-bit word, first bit to lsb, strobe left high to latch it
    task automatic send(input logic [23:0] w);
        ser_strobe = 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            ser_data = w[i];
            #62.5 ser_clk = 1'b1;
            #45 ser_data = ~w[i];     // hold over, line no longer valid
            #17.5 ser_clk = 1'b0;
        end
        #100 ser_strobe = 1'b1;
    endtask
    // end of the strobe pulse; its width is the host's cycle count
    task automatic drop();
        ser_strobe = 1'b0;
    endtask
endmodule

/* verification/synth_serial_ctrl_chk.sv */
// port assertions for the synthesizer control logic
`timescale 1ns/100ps
`define SC synth_ctrl_pkg::
module synth_serial_ctrl_chk
(
    input wire logic        core_clk,           // clock
    input wire logic        rst_n,              // reset
    input wire logic        ser_strobe,         // strobe pin
    input wire logic        main_pd_up,         // main up
    input wire logic        main_in_window,     // main window
    input wire logic        aux_in_window,      // aux window
    input wire logic        main_div_cycle_end, // boundary
    input wire logic        prop_pump_up,       // prop up
    input wire logic [6:0]  prop_pump_out,      // prop scale
    input wire logic [6:0]  prop_pump_speedup,  // su scale
    input wire logic [6:0]  integral_pump_out,  // int scale
    input wire logic [6:0]  aux_pump_out,       // aux scale
    input wire logic        speedup,            // speed-up
    input wire logic        lock,               // lock
    input wire logic        main_power_up,      // main power
    input wire logic        aux_power_up,       // aux power
    input wire logic [15:0] n_ratio_active,     // ratio
    input wire logic [7:0]  comp_dac            // dac
);
    // all checks on the core clock, quiet during reset
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    lock_combine_a: assert property (lock == ((main_power_up | aux_power_up) &
        (!main_power_up | $past(main_in_window)) & (!aux_power_up | $past(aux_in_window))))
        else $error("lock mismatch");
    both_down_a: assert property (!main_power_up && !aux_power_up |-> !lock)
        else $error("lock with both loops down");
    prop_follow_a: assert property (prop_pump_up == ($past(main_pd_up) & main_power_up))
        else $error("prop pump not following detector");
    scale_pair_a: assert property (prop_pump_out == `SC PROP_LO ?
        (aux_pump_out == `SC AUX_LO && prop_pump_speedup == `SC SU_LO) :
        (prop_pump_out == `SC PROP_HI && aux_pump_out == `SC AUX_HI)) else $error("scale pair");
    int_scale_a: assert property (integral_pump_out == `SC INT_OFF ||
        integral_pump_out == (prop_pump_out == `SC PROP_HI ? `SC INT_HI : `SC INT_LO))
        else $error("integral scale wrong");
    ratio_step_a: assert property ($changed(n_ratio_active) |-> $past(main_div_cycle_end))
        else $error("ratio changed off boundary");
    dac_step_a: assert property ($changed(comp_dac) |-> $past(main_div_cycle_end))
        else $error("dac changed off boundary");
    speedup_rise_a: assert property ($rose(speedup) |-> ser_strobe)
        else $error("speed-up began without strobe");
    // main scenarios reached
    cover property ($rose(speedup));
    cover property ($changed(n_ratio_active));
    cover property ($rose(lock));
endmodule
bind synth_serial_ctrl synth_serial_ctrl_chk chk (.*);

/* verification/synth_serial_ctrl_tb.sv */
// self-checking bench for the synthesizer control logic
`timescale 1ns/100ps
`define PK synth_ctrl_pkg::
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module synth_serial_ctrl_tb;
    logic core_clk, rst_n, ser_clk, ser_strobe, ser_data, hw_power_pin, main_pd_up, main_pd_dn;
    logic aux_pd_up, aux_pd_dn, main_in_window, aux_in_window, main_div_cycle_end, speedup;
    logic prop_pump_up, prop_pump_dn, integral_pump_up, integral_pump_dn, aux_pump_up;
    logic aux_pump_dn, lock, main_power_up, aux_power_up, div_resync, fmod_active;
    logic [6:0] prop_pump_out, prop_pump_speedup, integral_pump_out, aux_pump_out;
    logic [15:0] n_ratio_active;
    logic [2:0] nf_active;
    logic [7:0] comp_dac;
    logic [9:0] ref_div;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_total, total_checks, seen;
    synth_serial_ctrl uut (.*);
    host_serial_model host (.ser_clk, .ser_strobe, .ser_data);
    // core clock and resync pulse counter
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (div_resync === 1'b1) seen++;
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // register write; valids drop when taken, response read when bvalid is sampled
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata} <= {32'(a), d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        repeat (40)
        begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= 32'(a);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        repeat (40)
        begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        {rd, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    // one serial word, then a fixed wait of 12 cycles with the strobe left high
    task automatic word(input logic [23:0] w);
        host.send(w);
        tick(12);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, several times the expected run
    initial
    begin
        #500000;
        err_total++;
        report_and_stop();
    end
    // test sequence
    initial
    begin
        {rst_n, hw_power_pin, main_pd_up, main_pd_dn, aux_pd_up, aux_pd_dn} = '0;
        {main_in_window, aux_in_window, main_div_cycle_end, seen, err_total, total_checks} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        tick(2);
        rst_n <= 1'b1;
        tick(10);
        axi_rd(`PK REG_ACTIVE);
        `CHK({rd, ref_div}, {32'h050888C0, 10'h051})
        axi_rd(8'h1C);
        `CHK({rd, rsp}, {32'h00000000, `PK RESP_SLVERR})
        axi_wr(`PK REG_STATUS, 32'hFFFFFFFF);
        `CHK(rsp, `PK RESP_SLVERR)
        $display("test defaults done");
        word(24'hA00000);
        for (int c = 3; c >= 0; c--)
        begin
            word(24'h800000 | 24'(c));
            `CHK({aux_pump_out, prop_pump_out, prop_pump_speedup}, c[0] ? {`PK AUX_LO,
                `PK PROP_LO, `PK SU_LO} : {`PK AUX_HI, `PK PROP_HI, `PK SU_HI})
            `CHK(integral_pump_out, c[1] ? `PK INT_OFF : c[0] ? `PK INT_LO : `PK INT_HI)
        end
        $display("test gain select done");
        word(24'h5233A5);
        `CHK({comp_dac, ref_div}, {8'h50, 10'h123})
        word(24'h0C48D0);
        `CHK({speedup, n_ratio_active}, {1'b1, 16'h88C0})
        main_div_cycle_end <= 1'b1;
        tick(1);
        main_div_cycle_end <= 1'b0;
        tick(2);
        `CHK({n_ratio_active, comp_dac, nf_active, fmod_active}, 28'h1234A56)
        host.drop();
        tick(12);
        `CHK(speedup, 1'b0)
        $display("test divider load done");
        word(24'hA00001);
        `CHK(speedup, 1'b1)
        word(24'hA00003);
        `CHK(speedup, 1'b0)
        word(24'hA00002);
        word(24'h0C48D0);
        `CHK(speedup, 1'b0)
        host.drop();
        word(24'hA00000);
        $display("test speed-up modes done");
        {main_in_window, aux_in_window, main_pd_up, aux_pd_up, main_pd_dn, aux_pd_dn} <= 6'h3F;
        tick(3);
        `CHK({lock, prop_pump_up, aux_pump_up, integral_pump_up, prop_pump_dn, aux_pump_dn, integral_pump_dn}, 7'h7F)
        aux_in_window <= 1'b0;
        tick(3);
        `CHK(lock, 1'b0)
        hw_power_pin <= 1'b1;
        tick(8);
        `CHK({main_power_up, aux_power_up, lock}, 3'h0)
        word(24'h5231A5);
        `CHK({main_power_up, aux_power_up, lock, seen == 2}, 4'hB)
        $display("test lock and power done");
        report_and_stop();
    end
endmodule
